// ==== hw/erb_opt_reg.sv ====
// erb_opt_reg: one optional register stage with bypass
// assumes clr_n is an asynchronous, active-low clear
`timescale 1ns/1ps
module erb_opt_reg #(
    parameter int unsigned W = 1
) (
    // clock and clear
    input  wire logic         clk,
    input  wire logic         clr_n,
    // control
    input  wire logic         en,
    input  wire logic         use_reg,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] held;
    logic [W-1:0] next_held;

    always_comb begin
        next_held = en ? d : held;
    end

    always_ff @(posedge clk or negedge clr_n) begin
        if (!clr_n) begin
            held <= '0;
        end else begin
            held <= next_held;
        end
    end

    assign q = use_reg ? held : d;

endmodule

// ==== hw/erb_pkg.sv ====
// erb_pkg: constants and carriers for the embedded RAM block
// assumes a 32-bit AXI4-Lite register slave and one 40 MHz clock
package erb_pkg;

    // ------------------------------------------------------------
    // storage shape
    // ------------------------------------------------------------
    localparam int unsigned ERB_BITS   = 4096;
    localparam int unsigned ERB_ADDR_W = 11;
    localparam int unsigned ERB_DATA_W = 16;
    localparam int unsigned ERB_ROWS   = ERB_BITS / ERB_DATA_W;
    localparam int unsigned ERB_ROW_W  = 8;
    localparam int unsigned ERB_PORTS  = 2;

    // organisation codes: 256x16, 512x8, 1024x4, 2048x2
    localparam logic [1:0] ERB_SHAPE_256X16  = 2'h0;
    localparam logic [1:0] ERB_SHAPE_512X8   = 2'h1;
    localparam logic [1:0] ERB_SHAPE_1024X4  = 2'h2;
    localparam logic [1:0] ERB_SHAPE_2048X2  = 2'h3;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0]  ERB_OFF_CTRL   = 4'h0;
    localparam logic [3:0]  ERB_OFF_STATUS = 4'h4;
    localparam logic [31:0] ERB_CTRL_RESET = 32'h0000_0000;

    // ctrl fields
    localparam int unsigned ERB_F_SHAPE   = 0;
    localparam int unsigned ERB_F_DUAL    = 2;
    localparam int unsigned ERB_F_REG_WD  = 8;
    localparam int unsigned ERB_F_REG_Q   = 9;
    localparam int unsigned ERB_F_REG_WA  = 10;
    localparam int unsigned ERB_F_REG_WE  = 11;
    localparam int unsigned ERB_F_REG_RA  = 12;
    localparam int unsigned ERB_F_REG_RE  = 13;
    localparam int unsigned ERB_F_SW_CLR  = 16;
    // status fields
    localparam int unsigned ERB_F_WCOUNT  = 16;

    localparam logic [1:0] ERB_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ERB_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ERB_ADDR_W-1:0] addr;
        logic [ERB_DATA_W-1:0] wdata;
        logic                  we;
        logic                  re;
    } erb_port_t;

    typedef struct packed {
        logic [1:0] shape;
        logic       dual;
        logic       reg_wd;
        logic       reg_q;
        logic       reg_wa;
        logic       reg_we;
        logic       reg_ra;
        logic       reg_re;
        logic       sw_clr;
    } erb_cfg_t;

    // row and bit offset of a word for a given shape
    function automatic logic [ERB_ROW_W-1:0] erb_row(input logic [ERB_ADDR_W-1:0] a,
                                                    input logic [1:0] s);
        logic [ERB_ADDR_W-1:0] sh;
        sh = a >> s;
        return sh[ERB_ROW_W-1:0];
    endfunction

    function automatic logic [3:0] erb_off(input logic [ERB_ADDR_W-1:0] a,
                                           input logic [1:0] s);
        logic [3:0] lane;
        logic [3:0] wid;
        lane = a[3:0] & ((4'h1 << s) - 4'h1);
        wid  = 4'(5'h10 >> s);
        return 4'(lane * wid);
    endfunction

    function automatic logic [ERB_DATA_W-1:0] erb_mask(input logic [1:0] s);
        return 16'(17'h1_0000 >> (5'h10 - (5'h10 >> s))) - 16'h0001 + 16'h0001 == 16'h0000
               ? 16'hffff : 16'((17'h1 << (5'h10 >> s)) - 17'h1);
    endfunction

endpackage

// ==== hw/erb_ram_block.sv ====
// erb_ram_block: 4096-bit embedded RAM block with AXI4-Lite setup registers
// assumes user logic on CLK drives both ports; clears may come from fabric
`timescale 1ns/1ps
module erb_ram_block
    import erb_pkg::*;
(
    // clock and reset
    input  wire logic                  CLK,
    input  wire logic                  RESET_N,
    // axi4-lite write
    input  wire logic [3:0]            S_AXI_AWADDR,
    input  wire logic                  S_AXI_AWVALID,
    output logic                       S_AXI_AWREADY,
    input  wire logic [31:0]           S_AXI_WDATA,
    input  wire logic [3:0]            S_AXI_WSTRB,
    input  wire logic                  S_AXI_WVALID,
    output logic                       S_AXI_WREADY,
    output logic [1:0]                 S_AXI_BRESP,
    output logic                       S_AXI_BVALID,
    input  wire logic                  S_AXI_BREADY,
    // axi4-lite read
    input  wire logic [3:0]            S_AXI_ARADDR,
    input  wire logic                  S_AXI_ARVALID,
    output logic                       S_AXI_ARREADY,
    output logic [31:0]                S_AXI_RDATA,
    output logic [1:0]                 S_AXI_RRESP,
    output logic                       S_AXI_RVALID,
    input  wire logic                  S_AXI_RREADY,
    // fabric control
    input  wire logic                  WR_CE,
    input  wire logic                  RD_CE,
    input  wire logic                  LOCAL_CLR,
    input  wire logic                  GLOBAL_CLR,
    input  wire logic                  BLK_SEL,
    // memory ports
    input  wire erb_port_t             A_PORT,
    input  wire erb_port_t             B_PORT,
    output logic [ERB_DATA_W-1:0]      A_Q,
    output logic [ERB_DATA_W-1:0]      B_Q
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic [1:0] rst_pipe;
    logic       rst_n;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    logic [31:0] ctrl, next_ctrl;
    logic [15:0] wcount, next_wcount;
    logic        aw_got, next_aw_got, w_got, next_w_got;
    logic [3:0]  aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic        bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0]  bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic        wr_go;
    logic [1:0]  wr_fire;
    erb_cfg_t    cfg;

    assign S_AXI_AWREADY = !aw_got && !bvalid;
    assign S_AXI_WREADY  = !w_got && !bvalid;
    assign S_AXI_ARREADY = !rvalid;
    assign S_AXI_BVALID  = bvalid;
    assign S_AXI_BRESP   = bresp;
    assign S_AXI_RVALID  = rvalid;
    assign S_AXI_RRESP   = rresp;
    assign S_AXI_RDATA   = rdata;
    assign wr_go = (aw_got || S_AXI_AWVALID) && (w_got || S_AXI_WVALID) && !bvalid;

    always_comb begin
        next_aw_got  = aw_got;
        next_w_got   = w_got;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_ctrl    = ctrl;
        next_bvalid  = bvalid && !S_AXI_BREADY;
        next_bresp   = bresp;
        next_rvalid  = rvalid && !S_AXI_RREADY;
        next_rresp   = rresp;
        next_rdata   = rdata;
        next_wcount  = wcount + 16'(wr_fire[0]) + 16'(wr_fire[1]);
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            next_aw_got  = 1'b1;
            next_aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            next_w_got  = 1'b1;
            next_w_data = S_AXI_WDATA;
            next_w_strb = S_AXI_WSTRB;
        end
        if (wr_go) begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = ERB_RESP_OKAY;
            if (next_aw_addr == ERB_OFF_CTRL) begin
                for (int i = 0; i < 4; i++) begin
                    if (next_w_strb[i]) begin
                        next_ctrl[i*8 +: 8] = next_w_data[i*8 +: 8];
                    end
                end
            end else if (next_aw_addr != ERB_OFF_STATUS) begin
                next_bresp = ERB_RESP_SLVERR;
            end
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            next_rvalid = 1'b1;
            next_rresp  = ERB_RESP_OKAY;
            case (S_AXI_ARADDR)
                ERB_OFF_CTRL: begin
                    next_rdata = ctrl;
                end
                ERB_OFF_STATUS: begin
                    next_rdata = {wcount, 13'h0000, cfg.dual, cfg.shape};
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = ERB_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            aw_addr <= 4'h0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            ctrl    <= ERB_CTRL_RESET;
            bvalid  <= 1'b0;
            bresp   <= 2'h0;
            rvalid  <= 1'b0;
            rresp   <= 2'h0;
            rdata   <= 32'h0000_0000;
            wcount  <= 16'h0000;
        end else begin
            aw_got  <= next_aw_got;
            w_got   <= next_w_got;
            aw_addr <= next_aw_addr;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            ctrl    <= next_ctrl;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            rvalid  <= next_rvalid;
            rresp   <= next_rresp;
            rdata   <= next_rdata;
            wcount  <= next_wcount;
        end
    end

    assign cfg.shape  = ctrl[ERB_F_SHAPE +: 2];
    assign cfg.dual   = ctrl[ERB_F_DUAL];
    assign cfg.reg_wd = ctrl[ERB_F_REG_WD];
    assign cfg.reg_q  = ctrl[ERB_F_REG_Q];
    assign cfg.reg_wa = ctrl[ERB_F_REG_WA];
    assign cfg.reg_we = ctrl[ERB_F_REG_WE];
    assign cfg.reg_ra = ctrl[ERB_F_REG_RA];
    assign cfg.reg_re = ctrl[ERB_F_REG_RE];
    assign cfg.sw_clr = ctrl[ERB_F_SW_CLR];

    // ------------------------------------------------------------
    // port paths
    // ------------------------------------------------------------
    // three clear sources plus software clear
    logic clr_n;
    assign clr_n = rst_n && !LOCAL_CLR && !GLOBAL_CLR && !cfg.sw_clr;

    logic [ERB_DATA_W-1:0] mem [ERB_ROWS];
    logic [ERB_ADDR_W-1:0] wa [ERB_PORTS];
    logic [ERB_ADDR_W-1:0] ra [ERB_PORTS];
    logic [ERB_DATA_W-1:0] wd [ERB_PORTS];
    logic [ERB_DATA_W-1:0] rd [ERB_PORTS];
    logic [ERB_DATA_W-1:0] qo [ERB_PORTS];
    logic [ERB_PORTS-1:0]  we, re;
    erb_port_t             pin [ERB_PORTS];

    assign pin[0] = A_PORT;
    assign pin[1] = B_PORT;

    for (genvar p = 0; p < ERB_PORTS; p++) begin : g_port
        // write-side on WR_CE, read-side on RD_CE
        erb_opt_reg #(.W(ERB_ADDR_W)) u_wa (.clk(CLK), .clr_n(clr_n), .en(WR_CE),
            .use_reg(cfg.reg_wa), .d(pin[p].addr), .q(wa[p]));
        erb_opt_reg #(.W(ERB_DATA_W)) u_wd (.clk(CLK), .clr_n(clr_n), .en(WR_CE),
            .use_reg(cfg.reg_wd), .d(pin[p].wdata), .q(wd[p]));
        erb_opt_reg #(.W(1)) u_we (.clk(CLK), .clr_n(clr_n), .en(WR_CE),
            .use_reg(cfg.reg_we), .d(pin[p].we), .q(we[p]));
        erb_opt_reg #(.W(ERB_ADDR_W)) u_ra (.clk(CLK), .clr_n(clr_n), .en(RD_CE),
            .use_reg(cfg.reg_ra), .d(pin[p].addr), .q(ra[p]));
        erb_opt_reg #(.W(1)) u_re (.clk(CLK), .clr_n(clr_n), .en(RD_CE),
            .use_reg(cfg.reg_re), .d(pin[p].re), .q(re[p]));
        // array read follows read address, optional output stage
        assign rd[p] = re[p] ? ((mem[erb_row(ra[p], cfg.shape)] >> erb_off(ra[p], cfg.shape))
                               & erb_mask(cfg.shape)) : '0;
        erb_opt_reg #(.W(ERB_DATA_W)) u_q (.clk(CLK), .clr_n(clr_n), .en(RD_CE),
            .use_reg(cfg.reg_q), .d(rd[p]), .q(qo[p]));
        // strobe gated by WR_CE; port b dual only
        assign wr_fire[p] = we[p] && WR_CE && BLK_SEL && (p == 0 || cfg.dual);
    end

    // deselected block drives zeros, outputs can be or-ed
    assign A_Q = BLK_SEL ? qo[0] : '0;
    assign B_Q = (BLK_SEL && cfg.dual) ? qo[1] : '0;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // 256 rows of 16 bits, lanes picked by shape
    logic [ERB_ROW_W-1:0]  row0, row1;
    logic [ERB_DATA_W-1:0] msk0, msk1, word0, word1;
    always_comb begin
        row0  = erb_row(wa[0], cfg.shape);
        row1  = erb_row(wa[1], cfg.shape);
        msk0  = erb_mask(cfg.shape) << erb_off(wa[0], cfg.shape);
        msk1  = erb_mask(cfg.shape) << erb_off(wa[1], cfg.shape);
        word0 = (mem[row0] & ~msk0) | ((wd[0] << erb_off(wa[0], cfg.shape)) & msk0);
        word1 = ((wr_fire[0] && row0 == row1) ? word0 : mem[row1]) & ~msk1;
        word1 = word1 | ((wd[1] << erb_off(wa[1], cfg.shape)) & msk1);
    end

    always_ff @(posedge CLK) begin
        if (wr_fire[0]) begin
            mem[row0] <= word0;
        end
        if (wr_fire[1]) begin
            mem[row1] <= word1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    a_cfg_shape: assert property (wr_go && next_aw_addr == ERB_OFF_CTRL && next_w_strb[0]
        |=> cfg.shape == $past(next_w_data[1:0])) else $error("shape not updated");
    a_write_count: assert property (wr_fire[0] && !wr_fire[1]
        |=> wcount == $past(wcount) + 16'h0001) else $error("write not counted");
    a_ce_gate: assert property (!WR_CE |-> wr_fire == 2'b00)
        else $error("write without enable");
    a_out_latency: assert property (cfg.reg_q && RD_CE && BLK_SEL && clr_n ##1 BLK_SEL
        && cfg.reg_q && clr_n |-> A_Q == $past(rd[0])) else $error("read latency wrong");
    a_out_hold: assert property (cfg.reg_q && !RD_CE && clr_n ##1 cfg.reg_q && clr_n
        && BLK_SEL && $stable(BLK_SEL) |-> $stable(A_Q)) else $error("output moved");
    a_clear: assert property (GLOBAL_CLR && cfg.reg_q |-> A_Q == '0 && B_Q == '0)
        else $error("clear ignored");
    a_single_port: assert property (!cfg.dual |-> !wr_fire[1] && B_Q == '0)
        else $error("port b active");
    a_deselect: assert property (!BLK_SEL |-> A_Q == '0 && wr_fire == 2'b00)
        else $error("deselected block active");
    a_bresp_hold: assert property (bvalid && !S_AXI_BREADY |=> bvalid && $stable(bresp))
        else $error("write response dropped");

    c_dual_write: cover property (wr_fire == 2'b11);
    c_shape_2bit: cover property (cfg.shape == ERB_SHAPE_2048X2 && wr_fire[0]);
    c_reg_read: cover property (cfg.reg_q && re[0] && RD_CE ##1 A_Q != '0);

endmodule

// ==== testbench/erb_fabric_model.sv ====
// erb_fabric_model: fabric user logic on both memory ports
// assumes one bench process calls its tasks, after reset release
`timescale 1ns/1ps
module erb_fabric_model
    import erb_pkg::*;
(
    // clock
    input  wire logic        clk,
    // memory ports
    output erb_port_t        a_port,
    output erb_port_t        b_port,
    input  wire logic [15:0] a_q,
    input  wire logic [15:0] b_q
);
    initial begin
        a_port = '0;
        b_port = '0;
    end

    // ------------------------------------------------------------
    // port drive
    // ------------------------------------------------------------
    // fabric presents request
    task automatic start(input logic b, input logic [10:0] a, input logic [15:0] d,
                         input logic we);
        erb_port_t p;
        p = '{addr: a, wdata: d, we: we, re: !we};
        @(posedge clk);
        if (b) b_port <= p;
        else a_port <= p;
    endtask

    task automatic idle();
        a_port <= '{addr: ~a_port.addr, wdata: ~a_port.wdata, we: 1'b0, re: 1'b0};
        b_port <= '{addr: ~b_port.addr, wdata: ~b_port.wdata, we: 1'b0, re: 1'b0};
    endtask

    task automatic op(input logic b, input logic [10:0] a, input logic [15:0] d,
                      input logic we, input int extra, output logic [15:0] qa,
                      output logic [15:0] qb);
        start(b, a, d, we);
        @(negedge clk);
        qa = a_q;
        qb = b_q;
        @(posedge clk);
        idle();
        repeat (extra) @(negedge clk);
        if (extra > 0) begin
            qa = a_q;
            qb = b_q;
        end
    endtask
endmodule

// ==== testbench/erb_ram_block_tb.sv ====
// erb_ram_block_tb: self-checking bench for the embedded RAM block
// assumes erb_fabric_model drives the memory ports; bench drives axi and controls
`timescale 1ns/1ps
module erb_ram_block_tb
    import erb_pkg::*;
;
    logic          clk, reset_n, dual;
    logic [3:0]    awaddr, araddr;
    logic [31:0]   wdata, rdata;
    logic [1:0]    bresp, rresp, shp;
    logic          awvalid, awready, wvalid, wready, bvalid, bready;
    logic          arvalid, arready, rvalid, rready;
    logic          wr_ce, rd_ce, local_clr, global_clr, blk_sel;
    erb_port_t     a_port, b_port;
    logic [15:0]   a_q, b_q;
    logic [4095:0] mem;
    int            mismatches, compares, wcount, ext;

    erb_ram_block u_erb_ram_block (
        .CLK(clk), .RESET_N(reset_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .WR_CE(wr_ce), .RD_CE(rd_ce),
        .LOCAL_CLR(local_clr), .GLOBAL_CLR(global_clr), .BLK_SEL(blk_sel),
        .A_PORT(a_port), .B_PORT(b_port), .A_Q(a_q), .B_Q(b_q)
    );
    erb_fabric_model u_erb_fabric_model (
        .clk(clk), .a_port(a_port), .b_port(b_port), .a_q(a_q), .b_q(b_q)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // checking and bus helpers
    // ------------------------------------------------------------
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // first bit of a word in the flat mirror
    function automatic int bitbase(input logic [10:0] a);
        return int'(a >> shp) * 16 + int'(a & ((11'h1 << shp) - 11'h1)) * (16 >> shp);
    endfunction

    function automatic logic [15:0] expq(input logic [10:0] a);
        logic [15:0] e;
        e = '0;
        for (int i = 0; i < (16 >> shp); i++) begin
            e[i] = mem[bitbase(a) + i];
        end
        return e;
    endfunction

    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, b;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        b = 1'b0;
        while (!b) begin
            @(negedge clk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            r = bresp;
            @(posedge clk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) bready <= 1'b0;
        end
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, got;
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        got = 1'b0;
        while (!got) begin
            @(negedge clk);
            ar = arvalid && arready;
            got = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar) arvalid <= 1'b0;
            if (got) rready <= 1'b0;
        end
    endtask

    task automatic set_ctrl(input logic [31:0] v);
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(ERB_OFF_CTRL, v, r);
        chk("ctrl bresp", 32'(ERB_RESP_OKAY), 32'(r));
        axi_rd(ERB_OFF_CTRL, d, r);
        chk("ctrl readback", v, d);
        shp = v[1:0];
        dual = v[ERB_F_DUAL];
        ext = int'(v[ERB_F_REG_RA]) + int'(v[ERB_F_REG_Q]);
    endtask

    task automatic mwr(input logic b, input logic [10:0] a, input logic [15:0] d);
        logic [15:0] qa, qb;
        d = d & 16'((17'h1 << (16 >> shp)) - 17'h1);
        u_erb_fabric_model.op(b, a, d, 1'b1, ext, qa, qb);
        if (wr_ce && blk_sel && (dual || !b)) begin
            for (int i = 0; i < (16 >> shp); i++) begin
                mem[bitbase(a) + i] = d[i];
            end
            wcount++;
        end
    endtask

    task automatic mrd(input logic b, input logic [10:0] a);
        logic [15:0] qa, qb, e;
        u_erb_fabric_model.op(b, a, 16'(~a), 1'b0, ext, qa, qb);
        e = blk_sel ? expq(a) : 16'h0000;
        if (b) chk("b_q", 32'(e), 32'(qb));
        else chk("a_q", 32'(e), 32'(qa));
        if (!dual) chk("b_q single", 32'h0, 32'(qb));
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [10:0] ad [8];
        void'($urandom(47400));
        {reset_n, awvalid, wvalid, bready, arvalid, rready, local_clr, global_clr} = '0;
        {awaddr, araddr, wdata, mismatches, compares, wcount, shp, dual, ext} = '0;
        {wr_ce, rd_ce, blk_sel} = 3'h7;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        axi_rd(ERB_OFF_CTRL, d, r);
        chk("ctrl reset", ERB_CTRL_RESET, d);
        axi_rd(4'h8, d, r);
        chk("unmapped rresp", 32'(ERB_RESP_SLVERR), 32'(r));
        axi_wr(4'hc, 32'h0000_0003, r);
        chk("unmapped bresp", 32'(ERB_RESP_SLVERR), 32'(r));
        axi_wr(ERB_OFF_STATUS, 32'hffff_ffff, r);
        chk("status bresp", 32'(ERB_RESP_OKAY), 32'(r));
        axi_rd(ERB_OFF_STATUS, d, r);
        chk("status read only", 32'h0, d);
        for (int s = 0; s < 4; s++) begin
            set_ctrl(32'(s));
            for (int n = 0; n < 8; n++) begin
                ad[n] = (n == 0) ? 11'((256 << s) - 1) : 11'($urandom % (256 << s));
                mwr(1'b0, ad[n], 16'($urandom));
            end
            for (int n = 0; n < 8; n++) begin
                mrd(1'b0, ad[n]);
            end
        end
        wr_ce <= 1'b0;
        mwr(1'b0, ad[2], ~expq(ad[2]));
        mrd(1'b0, ad[2]);
        wr_ce <= 1'b1;
        blk_sel <= 1'b0;
        mwr(1'b0, ad[3], ~expq(ad[3]));
        mrd(1'b0, ad[3]);
        blk_sel <= 1'b1;
        mrd(1'b0, ad[3]);
        set_ctrl(32'(ERB_SHAPE_512X8) | 32'h0000_0004);
        for (int n = 0; n < 6; n++) begin
            mwr(1'b1, ad[n] & 11'h1ff, 16'($urandom));
            mrd(1'b0, ad[n] & 11'h1ff);
            mrd(1'b1, ad[n] & 11'h1ff);
        end
        set_ctrl(32'h0000_3f00);
        for (int n = 0; n < 4; n++) begin
            mwr(1'b0, ad[n] & 11'h0ff, 16'($urandom));
            mrd(1'b0, ad[n] & 11'h0ff);
        end
        set_ctrl(32'h0000_0200);
        for (int c = 0; c < 2; c++) begin
            u_erb_fabric_model.start(1'b0, ad[c] & 11'h0ff, 16'h0000, 1'b0);
            repeat (2) @(negedge clk);
            chk("a_q registered", 32'(expq(ad[c] & 11'h0ff)), 32'(a_q));
            @(posedge clk);
            rd_ce <= 1'b0;
            @(posedge clk);
            {global_clr, local_clr} <= (c == 0) ? 2'h1 : 2'h2;
            @(negedge clk);
            chk("a_q cleared", 32'h0, 32'(a_q));
            @(posedge clk);
            {global_clr, local_clr} <= 2'h0;
            @(negedge clk);
            chk("a_q frozen", 32'h0, 32'(a_q));
            @(posedge clk);
            rd_ce <= 1'b1;
            @(posedge clk);
            u_erb_fabric_model.idle();
            @(negedge clk);
            chk("a_q reloaded", 32'(expq(ad[c] & 11'h0ff)), 32'(a_q));
        end
        axi_rd(ERB_OFF_STATUS, d, r);
        chk("status", {wcount[15:0], 13'h0, dual, shp}, d);
        summarize();
    end

    initial begin
        #(25 * 20000);
        mismatches++;
        summarize();
    end
endmodule
